// file: rtl/snc_pkg.sv
package snc_pkg;

	// ----------------------------------------
	// Parameter identifiers
	// ----------------------------------------
	localparam logic [7:0] ID_NODE_ADDR   = 8'h05;
	localparam logic [7:0] ID_BIT_RATE    = 8'h06;
	localparam logic [7:0] ID_COMMIT      = 8'h11;
	localparam logic [7:0] ID_OVERHEAT    = 8'hcc;
	localparam logic [7:0] ID_OVERVOLT    = 8'hcd;
	localparam logic [7:0] ID_UNDERVOLT   = 8'hce;
	localparam logic [7:0] ID_Q_CURRENT   = 8'hfa;
	localparam logic [7:0] ID_SPEED       = 8'hfb;
	localparam logic [7:0] ID_POS_DEV     = 8'hfc;

	// ----------------------------------------
	// Stored slots
	// ----------------------------------------
	localparam int         NUM_WORDS      = 8;
	localparam logic [2:0] SLOT_NODE_ADDR = 3'h0;
	localparam logic [2:0] SLOT_BIT_RATE  = 3'h1;
	localparam logic [2:0] SLOT_OVERHEAT  = 3'h2;
	localparam logic [2:0] SLOT_OVERVOLT  = 3'h3;
	localparam logic [2:0] SLOT_UNDERVOLT = 3'h4;
	localparam logic [2:0] SLOT_LAST      = 3'h4;
	localparam logic [2:0] SLOT_LOAD_END  = 3'h5;
	localparam logic [2:0] SLOT_NONE      = 3'h7;

	// ----------------------------------------
	// Factory values
	// ----------------------------------------
	localparam logic [15:0] FACTORY [0:7] = '{
		16'h001f, 16'h0004, 16'h0352, 16'h0226,
		16'h00b4, 16'h0000, 16'h0000, 16'h0000
	};

	// ----------------------------------------
	// Setting ranges and codes
	// ----------------------------------------
	localparam logic [15:0] NODE_ADDR_MIN  = 16'h0001;
	localparam logic [15:0] NODE_ADDR_MAX  = 16'h001f;
	localparam logic [15:0] OVERHEAT_MAX   = 16'h03e8;
	localparam logic [15:0] VOLTAGE_MAX    = 16'h02b2;
	localparam logic [15:0] COMMIT_VALUE   = 16'h0001;
	localparam logic [15:0] RATE_125K      = 16'h0000;
	localparam logic [15:0] RATE_250K      = 16'h0001;
	localparam logic [15:0] RATE_500K      = 16'h0002;
	localparam logic [15:0] RATE_1M        = 16'h0004;
	localparam logic [3:0]  SWITCH_STORED  = 4'h0;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_LOAD   = 4'b0001,
		ST_SAMPLE = 4'b0010,
		ST_IDLE   = 4'b0100,
		ST_SAVE   = 4'b1000
	} snc_state_t;

endpackage : snc_pkg

// file: rtl/snc_nvm.sv
`timescale 1ns/100ps
module snc_nvm (
	// Clock
	input  wire logic        clk_in,
	// Access
	input  wire logic        we_in,
	input  wire logic [2:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	output logic      [15:0] rdata_out
);

	// ----------------------------------------
	// Storage, kept across reset
	// ----------------------------------------
	logic [15:0] mem [0:7] = snc_pkg::FACTORY; // see [RULE1]
	logic [15:0] next_rdata;

	always_comb begin
		next_rdata = mem[addr_in];
	end

	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in; // see [RULE7]
		end
		rdata_out <= next_rdata;
	end

endmodule : snc_nvm

// file: rtl/snc_params.sv
// Contract
// [RULE1] Factory node address is 31
// [RULE2] Nonzero switch digit gives address 1 to 15
// [RULE3] Address chosen only at power-up
// [RULE4] Switch zero uses stored address
// [RULE5] Stored address accepts 1 to 31
// [RULE6] Writing 1 to commit saves parameters
// [RULE7] Unsaved changes lost; saved restored
// [RULE8] Rate codes 0,1,2,4 give 125k..1M
// [RULE9] Factory rate code is 4
// [RULE10] New rate applies after power cycle
// [RULE11] Host waits two seconds after power-up
// [RULE12] Host keeps node addresses unique
// [RULE13] Parameter 250 reports q-axis current
// [RULE14] Parameter 251 reports motor speed
// [RULE15] Parameter 252 reports position deviation
// [RULE16] Read-only, reserved, out-of-range writes refused
`timescale 1ns/100ps
module snc_params (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Parameter access
	input  wire logic        param_wr_in,
	input  wire logic        param_rd_in,
	input  wire logic [7:0]  param_id_in,
	input  wire logic [15:0] param_wdata_in,
	output logic      [15:0] param_rdata_out,
	output logic             param_ack_out,
	output logic             param_err_out,
	// Switch and monitors
	input  wire logic [3:0]  rotary_switch_in,
	input  wire logic [15:0] q_current_in,
	input  wire logic [15:0] speed_in,
	input  wire logic [15:0] position_dev_in,
	// Settings and status
	output logic      [4:0]  node_address_out,
	output logic      [2:0]  bit_rate_code_out,
	output logic             ready_out,
	output logic             busy_out,
	output logic      [15:0] overheat_threshold_out,
	output logic      [15:0] overvoltage_threshold_out,
	output logic      [15:0] undervoltage_threshold_out
);

	// ----------------------------------------
	// Decoding
	// ----------------------------------------
	function automatic logic [2:0] id_slot(input logic [7:0] id);
		case (id)
			snc_pkg::ID_NODE_ADDR: id_slot = snc_pkg::SLOT_NODE_ADDR;
			snc_pkg::ID_BIT_RATE:  id_slot = snc_pkg::SLOT_BIT_RATE;
			snc_pkg::ID_OVERHEAT:  id_slot = snc_pkg::SLOT_OVERHEAT;
			snc_pkg::ID_OVERVOLT:  id_slot = snc_pkg::SLOT_OVERVOLT;
			snc_pkg::ID_UNDERVOLT: id_slot = snc_pkg::SLOT_UNDERVOLT;
			default:               id_slot = snc_pkg::SLOT_NONE;
		endcase
	endfunction : id_slot

	function automatic logic in_range(input logic [2:0] slot,
		input logic [15:0] val);
		case (slot)
			snc_pkg::SLOT_NODE_ADDR: in_range =
				val >= snc_pkg::NODE_ADDR_MIN &&
				val <= snc_pkg::NODE_ADDR_MAX;
			snc_pkg::SLOT_BIT_RATE: in_range = // see [RULE8]
				val == snc_pkg::RATE_125K || val == snc_pkg::RATE_250K ||
				val == snc_pkg::RATE_500K || val == snc_pkg::RATE_1M;
			snc_pkg::SLOT_OVERHEAT: in_range = val <= snc_pkg::OVERHEAT_MAX;
			snc_pkg::SLOT_OVERVOLT,
			snc_pkg::SLOT_UNDERVOLT: in_range = val <= snc_pkg::VOLTAGE_MAX;
			default: in_range = 1'b0;
		endcase
	endfunction : in_range

	// ----------------------------------------
	// State
	// ----------------------------------------
	snc_pkg::snc_state_t state;
	snc_pkg::snc_state_t next_state;
	logic [2:0]  cnt;
	logic [2:0]  next_cnt;
	logic [15:0] work [0:7];
	logic [15:0] next_work [0:7];
	logic [3:0]  sw_meta;
	logic [3:0]  sw_sync;
	logic [3:0]  sw_cap;
	logic [3:0]  next_sw_cap;
	logic [4:0]  next_node;
	logic [2:0]  next_rate;
	logic        next_ack;
	logic        next_err;
	logic [15:0] next_rdata;
	logic        next_ready;
	logic        next_busy;
	logic        nvm_we;
	logic [15:0] nvm_rdata;
	logic [2:0]  req_slot;

	assign req_slot = id_slot(param_id_in);
	assign overheat_threshold_out     = work[snc_pkg::SLOT_OVERHEAT];
	assign overvoltage_threshold_out  = work[snc_pkg::SLOT_OVERVOLT];
	assign undervoltage_threshold_out = work[snc_pkg::SLOT_UNDERVOLT];

	// ----------------------------------------
	// Nonvolatile store
	// ----------------------------------------
	snc_nvm u_nvm (
		.clk_in    (clk_in),
		.we_in     (nvm_we),
		.addr_in   (cnt),
		.wdata_in  (work[cnt]),
		.rdata_out (nvm_rdata)
	);

	// ----------------------------------------
	// Switch synchroniser
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		sw_meta <= rotary_switch_in;
		sw_sync <= sw_meta;
	end

	// ----------------------------------------
	// Sequencer and parameter access
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_cnt   = cnt;
		next_work  = work;
		next_sw_cap = sw_cap;
		next_node  = node_address_out;
		next_rate  = bit_rate_code_out;
		next_ack   = 1'b0;
		next_err   = 1'b0;
		next_rdata = param_rdata_out;
		nvm_we     = 1'b0;
		case (state)
			snc_pkg::ST_LOAD: begin
				if (cnt != 3'h0) begin
					next_work[3'(cnt - 3'h1)] = nvm_rdata; // see [RULE7]
				end
				if (cnt == snc_pkg::SLOT_LOAD_END) begin
					next_state = snc_pkg::ST_SAMPLE;
					next_cnt   = 3'h0;
				end else begin
					next_cnt = 3'(cnt + 3'h1);
				end
			end
			snc_pkg::ST_SAMPLE: begin
				next_sw_cap = sw_sync; // see [RULE3]
				if (sw_sync != snc_pkg::SWITCH_STORED) begin
					next_node = {1'b0, sw_sync}; // see [RULE2]
				end else begin
					next_node = work[snc_pkg::SLOT_NODE_ADDR][4:0]; // see [RULE4]
				end
				next_rate  = work[snc_pkg::SLOT_BIT_RATE][2:0]; // see [RULE10]
				next_state = snc_pkg::ST_IDLE;
			end
			snc_pkg::ST_IDLE: begin
				if (param_wr_in) begin
					next_ack = 1'b1;
					if (param_id_in == snc_pkg::ID_COMMIT) begin
						if (param_wdata_in == snc_pkg::COMMIT_VALUE) begin
							next_state = snc_pkg::ST_SAVE; // see [RULE6]
							next_cnt   = 3'h0;
						end else begin
							next_err = 1'b1;
						end
					end else if (req_slot != snc_pkg::SLOT_NONE &&
						in_range(req_slot, param_wdata_in)) begin
						next_work[req_slot] = param_wdata_in; // see [RULE5]
					end else begin
						next_err = 1'b1; // see [RULE16]
					end
				end else if (param_rd_in) begin
					next_ack = 1'b1;
					case (param_id_in)
						snc_pkg::ID_Q_CURRENT: next_rdata = q_current_in; // see [RULE13]
						snc_pkg::ID_SPEED:     next_rdata = speed_in; // see [RULE14]
						snc_pkg::ID_POS_DEV:   next_rdata = position_dev_in; // see [RULE15]
						default: begin
							if (req_slot != snc_pkg::SLOT_NONE) begin
								next_rdata = work[req_slot];
							end else begin
								next_rdata = 16'h0000;
								next_err   = 1'b1;
							end
						end
					endcase
				end
			end
			snc_pkg::ST_SAVE: begin
				nvm_we = 1'b1; // see [RULE6]
				if (cnt == snc_pkg::SLOT_LAST) begin
					next_state = snc_pkg::ST_IDLE;
					next_cnt   = 3'h0;
				end else begin
					next_cnt = 3'(cnt + 3'h1);
				end
			end
			default: begin
				next_state = snc_pkg::ST_LOAD;
				next_cnt   = 3'h0;
			end
		endcase
		next_ready = next_state == snc_pkg::ST_IDLE ||
			next_state == snc_pkg::ST_SAVE;
		next_busy  = next_state != snc_pkg::ST_IDLE;
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= snc_pkg::ST_LOAD;
			cnt   <= 3'h0;
			for (int i = 0; i < snc_pkg::NUM_WORDS; i++) begin
				work[i] <= snc_pkg::FACTORY[i];
			end
			sw_cap            <= 4'h0;
			node_address_out  <= snc_pkg::FACTORY[0][4:0]; // see [RULE1]
			bit_rate_code_out <= snc_pkg::FACTORY[1][2:0]; // see [RULE9]
			param_ack_out     <= 1'b0;
			param_err_out     <= 1'b0;
			param_rdata_out   <= 16'h0000;
			ready_out         <= 1'b0;
			busy_out          <= 1'b1;
		end else begin
			state             <= next_state;
			cnt               <= next_cnt;
			work              <= next_work;
			sw_cap            <= next_sw_cap;
			node_address_out  <= next_node;
			bit_rate_code_out <= next_rate;
			param_ack_out     <= next_ack;
			param_err_out     <= next_err;
			param_rdata_out   <= next_rdata;
			ready_out         <= next_ready;
			busy_out          <= next_busy;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_taken_wr;
		state == snc_pkg::ST_IDLE && param_wr_in;
	endsequence

	sequence s_commit_req;
		s_taken_wr ##0 param_id_in == snc_pkg::ID_COMMIT &&
			param_wdata_in == snc_pkg::COMMIT_VALUE;
	endsequence

	sequence s_save_run;
		busy_out [*5] ##1 !busy_out;
	endsequence

	sequence s_taken_rd(logic [7:0] id);
		state == snc_pkg::ST_IDLE && !param_wr_in && param_rd_in &&
			param_id_in == id;
	endsequence

	a_switch_addr: assert property (@(posedge clk_in) // see [RULE2]
		disable iff (rst_in) $rose(ready_out) && sw_cap != 4'h0 |->
			node_address_out == {1'b0, sw_cap})
		else $error("switch address not applied");

	a_stored_addr: assert property (@(posedge clk_in) // see [RULE4]
		disable iff (rst_in) $rose(ready_out) && sw_cap == 4'h0 |->
			node_address_out == work[snc_pkg::SLOT_NODE_ADDR][4:0])
		else $error("stored address not applied");

	a_addr_hold: assert property (@(posedge clk_in) // see [RULE3]
		disable iff (rst_in) ready_out && $past(ready_out) |->
			$stable(node_address_out))
		else $error("node address changed after power-up");

	a_rate_hold: assert property (@(posedge clk_in) // see [RULE10]
		disable iff (rst_in) ready_out && $past(ready_out) |->
			$stable(bit_rate_code_out))
		else $error("bit rate changed after power-up");

	a_commit_run: assert property (@(posedge clk_in) // see [RULE6]
		disable iff (rst_in) s_commit_req |=> s_save_run)
		else $error("commit did not run five save cycles");

	a_addr_range: assert property (@(posedge clk_in) // see [RULE5]
		disable iff (rst_in) s_taken_wr ##0 param_id_in == snc_pkg::ID_NODE_ADDR &&
			(param_wdata_in == 16'h0000 || param_wdata_in > 16'h001f) |=>
			param_err_out && $stable(work[snc_pkg::SLOT_NODE_ADDR]))
		else $error("out-of-range address accepted");

	a_ro_refuse: assert property (@(posedge clk_in) // see [RULE16]
		disable iff (rst_in) s_taken_wr ##0 param_id_in == snc_pkg::ID_SPEED |=>
			param_ack_out && param_err_out)
		else $error("monitor write not refused");

	a_qcur_read: assert property (@(posedge clk_in) // see [RULE13]
		disable iff (rst_in) s_taken_rd(snc_pkg::ID_Q_CURRENT) |=>
			param_rdata_out == $past(q_current_in) && !param_err_out)
		else $error("q-axis current read wrong");

	a_speed_read: assert property (@(posedge clk_in) // see [RULE14]
		disable iff (rst_in) s_taken_rd(snc_pkg::ID_SPEED) |=>
			param_rdata_out == $past(speed_in))
		else $error("speed read wrong");

	a_posdev_read: assert property (@(posedge clk_in) // see [RULE15]
		disable iff (rst_in) s_taken_rd(snc_pkg::ID_POS_DEV) |=>
			param_rdata_out == $past(position_dev_in))
		else $error("position deviation read wrong");

	a_powerup_load: assert property (@(posedge clk_in) // see [RULE7]
		$fell(rst_in) |-> ##[1:10] ready_out)
		else $error("power-up restore did not finish");

	a_rate_code: assert property (@(posedge clk_in) // see [RULE8]
		disable iff (rst_in) s_taken_wr ##0 param_id_in == snc_pkg::ID_BIT_RATE &&
			param_wdata_in == 16'h0003 |=> param_err_out)
		else $error("illegal rate code accepted");

endmodule : snc_params

// file: test/snc_host.sv
`timescale 1ns/100ps
module snc_host (
	// Clock
	input  wire logic        clk_in,
	// Device answer
	input  wire logic        busy_in,
	input  wire logic        ack_in,
	input  wire logic        err_in,
	input  wire logic [15:0] rdata_in,
	// Requests
	output logic             wr_out,
	output logic             rd_out,
	output logic      [7:0]  id_out,
	output logic      [15:0] wdata_out
);
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		id_out = 8'h00;
		wdata_out = 16'h0000;
	end

	// ----------------------------------------
	// Host transfers
	// ----------------------------------------
	task automatic wait_ready(output logic ok);
		int n;
		ok = 1'b0;
		for (n = 0; n < 40 && !ok; n++) begin
			@(posedge clk_in);
			#1;
			ok = (busy_in === 1'b0);
		end
		repeat (2) @(posedge clk_in);
		#1;
	endtask : wait_ready

	task automatic access(input logic w, input logic [7:0] id,
		input logic [15:0] d, output logic [15:0] q,
		output logic ack, output logic err);
		int n;
		ack = 1'b0;
		err = 1'b0;
		q = 16'h0000;
		@(posedge clk_in);
		#1;
		wr_out = w;
		rd_out = !w;
		id_out = id;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		wr_out = 1'b0;
		rd_out = 1'b0;
		id_out = ~id;
		wdata_out = ~d;
		for (n = 0; n < 2 && ack !== 1'b1; n++) begin
			if (n > 0) begin
				@(posedge clk_in);
				#1;
			end
			ack = ack_in;
			err = err_in;
			q = rdata_in;
		end
	endtask : access
endmodule : snc_host

// file: test/tb.sv
`timescale 1ns/100ps
module tb;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic [3:0]  sw = 4'h0;
	logic [15:0] qc = 16'h0000;
	logic [15:0] spd = 16'h0000;
	logic [15:0] pdev = 16'h0000;
	logic        wr;
	logic        rd;
	logic [7:0]  id;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        ack;
	logic        err;
	logic        busy;
	logic        ready;
	logic [4:0]  node;
	logic [2:0]  rate;
	logic [15:0] oh;
	logic [15:0] ov;
	logic [15:0] uv;
	int          mismatches = 0;
	int          n_checks = 0;
	int          cycles = 0;

	always #2 clk_in = ~clk_in;

	snc_params dut_u (.clk_in(clk_in), .rst_in(rst_in), .param_wr_in(wr),
		.param_rd_in(rd), .param_id_in(id), .param_wdata_in(wdata),
		.param_rdata_out(rdata), .param_ack_out(ack), .param_err_out(err),
		.rotary_switch_in(sw), .q_current_in(qc), .speed_in(spd),
		.position_dev_in(pdev), .node_address_out(node),
		.bit_rate_code_out(rate), .ready_out(ready), .busy_out(busy),
		.overheat_threshold_out(oh), .overvoltage_threshold_out(ov),
		.undervoltage_threshold_out(uv));

	snc_host host_u (.clk_in(clk_in), .busy_in(busy), .ack_in(ack),
		.err_in(err), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
		.id_out(id), .wdata_out(wdata));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			$display("wrong value at %0t: timeout", $time);
			mismatches = mismatches + 1;
			final_report();
		end
	end

	task automatic chk_val(input logic [15:0] got, exp, input string what);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask : chk_val

	task automatic power_up(input logic [3:0] s);
		logic ok;
		@(posedge clk_in);
		#1;
		sw = s;
		rst_in = 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		host_u.wait_ready(ok);
		chk_val({15'h0000, ok & ready}, 16'h0001, "ready");
	endtask : power_up

	task automatic acc_chk(input logic w, input logic [7:0] i,
		input logic [15:0] d, input logic e);
		logic [15:0] q;
		logic a;
		logic f;
		host_u.access(w, i, d, q, a, f);
		chk_val({15'h0000, a}, 16'h0001, "ack");
		chk_val({15'h0000, f}, {15'h0000, e}, "err");
		if (!w) begin
			chk_val(q, e ? 16'h0000 : d, "rdata");
		end
	endtask : acc_chk

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		logic [15:0] q;
		logic a;
		logic f;
		logic [15:0] codes [5];
		logic [3:0] digs [3];
		codes = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0003};
		digs = '{4'h1, 4'ha, 4'hf};
		power_up(4'h0);
		chk_val({11'h000, node}, 16'h001f, "node");
		chk_val({13'h0000, rate}, 16'h0004, "rate");
		chk_val(oh, 16'h0352, "overheat");
		chk_val(ov, 16'h0226, "overvolt");
		chk_val(uv, 16'h00b4, "undervolt");
		acc_chk(1'b0, snc_pkg::ID_NODE_ADDR, 16'h001f, 1'b0);
		acc_chk(1'b0, snc_pkg::ID_BIT_RATE, 16'h0004, 1'b0);
		for (int k = 0; k < 5; k++) begin
			acc_chk(1'b1, snc_pkg::ID_BIT_RATE, codes[k], k == 4);
		end
		acc_chk(1'b0, snc_pkg::ID_BIT_RATE, 16'h0004, 1'b0);
		chk_val({13'h0000, rate}, 16'h0004, "rate kept");
		acc_chk(1'b1, snc_pkg::ID_NODE_ADDR, 16'h0000, 1'b1);
		acc_chk(1'b1, snc_pkg::ID_NODE_ADDR, 16'h0020, 1'b1);
		acc_chk(1'b1, snc_pkg::ID_NODE_ADDR, 16'h001f, 1'b0);
		acc_chk(1'b1, snc_pkg::ID_NODE_ADDR, 16'h0009, 1'b0);
		acc_chk(1'b0, snc_pkg::ID_NODE_ADDR, 16'h0009, 1'b0);
		chk_val({11'h000, node}, 16'h001f, "node kept");
		acc_chk(1'b1, snc_pkg::ID_OVERHEAT, 16'h03e9, 1'b1);
		acc_chk(1'b1, snc_pkg::ID_OVERHEAT, 16'h03e8, 1'b0);
		acc_chk(1'b1, snc_pkg::ID_OVERVOLT, 16'h02b3, 1'b1);
		acc_chk(1'b1, snc_pkg::ID_OVERVOLT, 16'h02b2, 1'b0);
		acc_chk(1'b1, snc_pkg::ID_UNDERVOLT, 16'h02b3, 1'b1);
		chk_val(oh, 16'h03e8, "overheat");
		chk_val(ov, 16'h02b2, "overvolt");
		chk_val(uv, 16'h00b4, "undervolt");
		qc = 16'h1aaa;
		spd = 16'h7fff;
		pdev = 16'h8001;
		acc_chk(1'b0, snc_pkg::ID_Q_CURRENT, 16'h1aaa, 1'b0);
		acc_chk(1'b0, snc_pkg::ID_SPEED, 16'h7fff, 1'b0);
		acc_chk(1'b0, snc_pkg::ID_POS_DEV, 16'h8001, 1'b0);
		acc_chk(1'b1, snc_pkg::ID_SPEED, 16'h0005, 1'b1);
		acc_chk(1'b1, 8'hfd, 16'h0005, 1'b1);
		acc_chk(1'b0, 8'hfd, 16'h0000, 1'b1);
		acc_chk(1'b1, snc_pkg::ID_BIT_RATE, 16'h0002, 1'b0);
		chk_val({13'h0000, rate}, 16'h0004, "rate unchanged");
		acc_chk(1'b1, snc_pkg::ID_COMMIT, 16'h0002, 1'b1);
		acc_chk(1'b1, snc_pkg::ID_COMMIT, 16'h0001, 1'b0);
		host_u.access(1'b1, snc_pkg::ID_NODE_ADDR, 16'h0003, q, a,
			f);
		chk_val({15'h0000, a}, 16'h0000, "dropped while busy");
		host_u.wait_ready(a);
		acc_chk(1'b1, snc_pkg::ID_NODE_ADDR, 16'h0014, 1'b0);
		acc_chk(1'b1, snc_pkg::ID_OVERHEAT, 16'h0005, 1'b0);
		power_up(4'h0);
		chk_val({11'h000, node}, 16'h0009, "saved node");
		chk_val({13'h0000, rate}, 16'h0002, "saved rate");
		chk_val(oh, 16'h03e8, "saved overheat");
		acc_chk(1'b0, snc_pkg::ID_NODE_ADDR, 16'h0009, 1'b0);
		for (int k = 0; k < 3; k++) begin
			power_up(digs[k]);
			chk_val({11'h000, node}, {12'h000, digs[k]}, "switch");
		end
		sw = 4'h3;
		repeat (10) @(posedge clk_in);
		#1;
		chk_val({11'h000, node}, 16'h000f, "switch late");
		final_report();
	end
endmodule : tb
